/* logic/qsf_core.v */
// Serial flash host interface: command decode, lanes and array addressing
// Behaviour
// - Array is 65,536 pages of 256 bytes
// - Program stays in one page, wraps
// - Erase aligned 16, 128, 256 pages or chip
// - 4096 sectors, 512 and 256 blocks, 24-bit span
// - Inputs on rising, outputs on falling clock
// - Works with clock modes 0 and 3
// - Single lane: in on lane 0, out lane 1
// - Dual reads use lanes 0 and 1
// - Quad reads use all four lanes
// - Quad instructions refused without quad enable
// - 38h enters, FFh leaves four-lane mode
// - Four-lane instruction takes two clocks
// - Only one instruction mode active
// - Resets return to single-lane instruction mode
// - Four-lane entry refused without quad enable
// - Four-lane mode uses lanes 0 to 3
// - Double-rate read only with quad enabled
// - Double-rate instruction sampled on rising only
// - Double-rate address and data on both edges
// - Select must fall first; high releases lanes
// - Pause only in single and dual operation
`timescale 1ns/10ps
`default_nettype none
`include "qsf_consts.vh"
module qsf_core (
	input wire ref_clk,
	input wire sys_rst,
	input wire spi_sck,
	input wire spi_cs_n,
	input wire io_lane_0_in,
	output wire io_lane_0_out,
	output wire io_lane_0_oe,
	input wire io_lane_1_in,
	output wire io_lane_1_out,
	output wire io_lane_1_oe,
	input wire io_lane_2_in,
	output wire io_lane_2_out,
	output wire io_lane_2_oe,
	input wire io_lane_3_in,
	output wire io_lane_3_out,
	output wire io_lane_3_oe,
	input wire quad_enable_bit,
	output wire four_lane_instruction_mode,
	output wire arr_rd_start,
	output wire arr_rd_active,
	output wire [23:0] arr_rd_addr,
	input wire [7:0] arr_rd_data,
	input wire arr_rd_valid,
	output wire arr_rd_ready,
	output wire prog_valid,
	output wire [23:0] prog_addr,
	output wire [7:0] prog_data,
	output wire erase_valid,
	output wire [1:0] erase_kind,
	output wire [23:0] erase_addr,
	output wire soft_reset,
	output wire cmd_reject,
	output wire busy
);
	// ------------------------------------------------------------
	// States and kinds
	// ------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CMD = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_DUMMY = 3'h3;
	localparam [2:0] ST_RDATA = 3'h4;
	localparam [2:0] ST_WDATA = 3'h5;
	localparam [2:0] ST_DONE = 3'h6;
	localparam [1:0] K_NONE = 2'h0;
	localparam [1:0] K_READ = 2'h1;
	localparam [1:0] K_PROG = 2'h2;
	localparam [1:0] K_ERASE = 2'h3;
	localparam integer SRST_I = `QSF_SRST_CYC;
	localparam [15:0] SRST_CYC = SRST_I[15:0];

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function [23:0] shin;
		input [23:0] s;
		input [2:0] w;
		input [3:0] l;
		begin
			case (w)
				3'h4: shin = {s[19:0], l};
				3'h2: shin = {s[21:0], l[1:0]};
				default: shin = {s[22:0], l[0]};
			endcase
		end
	endfunction

	function [3:0] lanes_out;
		input [2:0] w;
		input [7:0] b;
		begin
			case (w)
				3'h4: lanes_out = b[7:4];
				3'h2: lanes_out = {2'h0, b[7:6]};
				default: lanes_out = {2'h0, b[7], 1'b0};
			endcase
		end
	endfunction

	function [3:0] lane_mask;
		input [2:0] w;
		begin
			case (w)
				3'h4: lane_mask = 4'hf;
				3'h2: lane_mask = 4'h3;
				default: lane_mask = 4'h2;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisation and edges
	// ------------------------------------------------------------
	wire [5:0] pins_s;
	wire sck_s;
	wire cs_s;
	wire [3:0] li;
	reg sck_d_reg;
	qsf_sync #(.W(6)) u_sync (
		.clk(ref_clk),
		.rst(sys_rst),
		.d({spi_sck, spi_cs_n, io_lane_3_in, io_lane_2_in, io_lane_1_in, io_lane_0_in}),
		.q(pins_s)
	);
	assign sck_s = pins_s[5];
	assign cs_s = pins_s[4];
	assign li = pins_s[3:0];

	reg [2:0] state_reg;
	reg qpi_reg;
	reg armed_reg;
	reg rst_en_reg;
	reg [15:0] busy_cnt_reg;
	reg [23:0] sh_reg;
	reg [5:0] cnt_reg;
	reg [23:0] addr_reg;
	reg [2:0] aw_reg;
	reg [2:0] dw_reg;
	reg [3:0] dum_reg;
	reg dtr_reg;
	reg [1:0] kind_reg;
	reg [1:0] ek_reg;
	reg [7:0] out_sh_reg;
	reg [3:0] out_cnt_reg;
	reg [3:0] lane_o_reg;
	reg drv_reg;
	reg erase_pend_reg;
	reg rd_start_reg;
	reg prog_valid_reg;
	reg [23:0] prog_addr_reg;
	reg [7:0] prog_data_reg;
	reg erase_valid_reg;
	reg [23:0] erase_addr_reg;
	reg soft_rst_reg;
	reg reject_reg;

	// Pause pin only acts in single and dual operation
	wire hold_act = ~cs_s & ~quad_enable_bit & ~qpi_reg & ~li[3];
	wire act = ~cs_s & ~hold_act;
	wire rise_e = act & sck_s & ~sck_d_reg;
	wire fall_e = act & ~sck_s & sck_d_reg;
	wire in_edge = dtr_reg ? (rise_e | fall_e) : rise_e;
	wire out_edge = dtr_reg ? (rise_e | fall_e) : fall_e;
	wire [2:0] base_w = qpi_reg ? 3'h4 : 3'h1;

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	wire [23:0] cmd_sh = shin(sh_reg, base_w, li);
	wire [7:0] cmd_byte = cmd_sh[7:0];
	reg [2:0] dec_aw;
	reg [2:0] dec_dw;
	reg [3:0] dec_dum;
	reg dec_quad;
	reg dec_dtr;
	reg dec_spi;
	reg [1:0] dec_kind;
	reg [1:0] dec_ek;
	always @* begin
		dec_aw = base_w;
		dec_dw = base_w;
		dec_dum = 4'h0;
		dec_quad = 1'b0;
		dec_dtr = 1'b0;
		dec_spi = 1'b0;
		dec_kind = K_NONE;
		dec_ek = `QSF_ER_SECT;
		case (cmd_byte)
			`QSF_CMD_READ: dec_kind = K_READ;
			`QSF_CMD_FAST: begin
				dec_kind = K_READ;
				dec_dum = `QSF_DUM_FAST;
			end
			`QSF_CMD_DUAL_O: begin
				dec_kind = K_READ;
				dec_dw = 3'h2;
				dec_dum = `QSF_DUM_FAST;
				dec_spi = 1'b1;
			end
			`QSF_CMD_DUAL_IO: begin
				dec_kind = K_READ;
				dec_aw = 3'h2;
				dec_dw = 3'h2;
				dec_dum = `QSF_DUM_DUAL_IO;
				dec_spi = 1'b1;
			end
			`QSF_CMD_QUAD_O: begin
				dec_kind = K_READ;
				dec_dw = 3'h4;
				dec_dum = `QSF_DUM_FAST;
				dec_quad = 1'b1;
			end
			`QSF_CMD_QUAD_IO: begin
				dec_kind = K_READ;
				dec_aw = 3'h4;
				dec_dw = 3'h4;
				dec_dum = `QSF_DUM_QUAD_IO;
				dec_quad = 1'b1;
			end
			`QSF_CMD_DTR_QIO: begin
				dec_kind = K_READ;
				dec_aw = 3'h4;
				dec_dw = 3'h4;
				dec_dum = `QSF_DUM_DTR;
				dec_quad = 1'b1;
				dec_dtr = 1'b1;
			end
			`QSF_CMD_PROG: dec_kind = K_PROG;
			`QSF_CMD_ER_4K: dec_kind = K_ERASE;
			`QSF_CMD_ER_32K: begin
				dec_kind = K_ERASE;
				dec_ek = `QSF_ER_B32;
			end
			`QSF_CMD_ER_64K: begin
				dec_kind = K_ERASE;
				dec_ek = `QSF_ER_B64;
			end
			default: dec_kind = K_NONE;
		endcase
	end
	wire dec_ok = ~(dec_quad & ~quad_enable_bit) & ~(dec_spi & qpi_reg);
	wire is_chip = (cmd_byte == `QSF_CMD_ER_CHIP) || (cmd_byte == `QSF_CMD_ER_CHIP2);

	// ------------------------------------------------------------
	// Read data buffer
	// ------------------------------------------------------------
	wire [7:0] buf_data;
	wire buf_valid;
	wire rd_byte_edge = (state_reg == ST_RDATA) && out_edge && (out_cnt_reg == 4'h0);
	wire [7:0] out_src = (out_cnt_reg == 4'h0) ? (buf_valid ? buf_data : 8'h00) : out_sh_reg;
	qsf_buf2 #(.WIDTH(8), .DEPTH(2), .AW(1)) u_buf (
		.clk(ref_clk),
		.rst(sys_rst),
		.flush(rd_start_reg | cs_s),
		.in_valid(arr_rd_valid),
		.in_ready(arr_rd_ready),
		.in_data(arr_rd_data),
		.out_valid(buf_valid),
		.out_ready(rd_byte_edge),
		.out_data(buf_data)
	);

	wire [23:0] a_sh = shin(sh_reg, aw_reg, li);
	wire [23:0] w_sh = shin(sh_reg, dw_reg, li);
	wire [5:0] cnt_a = cnt_reg + {3'h0, aw_reg};
	wire [5:0] cnt_w = cnt_reg + {3'h0, dw_reg};
	wire [5:0] cnt_c = cnt_reg + {3'h0, base_w};

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_d_reg <= 1'b0;
			state_reg <= ST_IDLE;
			qpi_reg <= 1'b0;
			armed_reg <= 1'b0;
			rst_en_reg <= 1'b0;
			busy_cnt_reg <= 16'h0000;
			sh_reg <= 24'h000000;
			cnt_reg <= 6'h00;
			addr_reg <= 24'h000000;
			aw_reg <= 3'h1;
			dw_reg <= 3'h1;
			dum_reg <= 4'h0;
			dtr_reg <= 1'b0;
			kind_reg <= K_NONE;
			ek_reg <= `QSF_ER_SECT;
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 4'h0;
			lane_o_reg <= 4'h0;
			drv_reg <= 1'b0;
			erase_pend_reg <= 1'b0;
			rd_start_reg <= 1'b0;
			prog_valid_reg <= 1'b0;
			prog_addr_reg <= 24'h000000;
			prog_data_reg <= 8'h00;
			erase_valid_reg <= 1'b0;
			erase_addr_reg <= 24'h000000;
			soft_rst_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck_s;
			rd_start_reg <= 1'b0;
			prog_valid_reg <= 1'b0;
			erase_valid_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
			reject_reg <= 1'b0;
			if (busy_cnt_reg != 16'h0000) begin
				busy_cnt_reg <= busy_cnt_reg - 16'h0001;
			end
			if (cs_s) begin
				armed_reg <= 1'b1;
				state_reg <= ST_IDLE;
				drv_reg <= 1'b0;
				dtr_reg <= 1'b0;
				out_cnt_reg <= 4'h0;
				if (erase_pend_reg) begin
					erase_pend_reg <= 1'b0;
					erase_valid_reg <= 1'b1;
					erase_kind_sel(ek_reg);
				end
			end else begin
				case (state_reg)
					ST_IDLE: begin
						cnt_reg <= 6'h00;
						sh_reg <= 24'h000000;
						if (armed_reg && busy_cnt_reg == 16'h0000) begin
							state_reg <= ST_CMD;
						end else begin
							state_reg <= ST_DONE;
						end
					end
					ST_CMD: if (rise_e) begin
						sh_reg <= cmd_sh;
						cnt_reg <= cnt_c;
						if (cnt_c == 6'h08) begin
							cnt_reg <= 6'h00;
							sh_reg <= 24'h000000;
							state_reg <= ST_DONE;
							rst_en_reg <= (cmd_byte == `QSF_CMD_RST_EN);
							aw_reg <= dec_aw;
							dw_reg <= dec_dw;
							dum_reg <= dec_dum;
							kind_reg <= dec_kind;
							ek_reg <= dec_ek;
							if (cmd_byte == `QSF_CMD_QPI_ON) begin
								if (quad_enable_bit) begin
									qpi_reg <= 1'b1;
								end else begin
									reject_reg <= 1'b1;
								end
							end else if (cmd_byte == `QSF_CMD_QPI_OFF) begin
								qpi_reg <= 1'b0;
							end else if (cmd_byte == `QSF_CMD_RST) begin
								if (rst_en_reg) begin
									qpi_reg <= 1'b0;
									soft_rst_reg <= 1'b1;
									busy_cnt_reg <= SRST_CYC;
								end
							end else if (is_chip) begin
								ek_reg <= `QSF_ER_CHIP;
								erase_pend_reg <= 1'b1;
							end else if (dec_kind != K_NONE) begin
								if (dec_ok) begin
									dtr_reg <= dec_dtr;
									state_reg <= ST_ADDR;
								end else begin
									reject_reg <= 1'b1;
								end
							end
						end
					end
					ST_ADDR: if (in_edge) begin
						sh_reg <= a_sh;
						cnt_reg <= cnt_a;
						if (cnt_a == `QSF_ADDR_LAST) begin
							addr_reg <= a_sh;
							cnt_reg <= 6'h00;
							sh_reg <= 24'h000000;
							if (kind_reg == K_READ) begin
								rd_start_reg <= 1'b1;
								state_reg <= (dum_reg == 4'h0) ? ST_RDATA : ST_DUMMY;
							end else if (kind_reg == K_PROG) begin
								state_reg <= ST_WDATA;
							end else begin
								erase_pend_reg <= 1'b1;
								state_reg <= ST_DONE;
							end
						end
					end
					ST_DUMMY: if (rise_e) begin
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg + 6'h01 == {2'h0, dum_reg}) begin
							state_reg <= ST_RDATA;
						end
					end
					ST_RDATA: if (out_edge) begin
						drv_reg <= 1'b1;
						lane_o_reg <= lanes_out(dw_reg, out_src);
						out_sh_reg <= out_src << dw_reg;
						out_cnt_reg <= ((out_cnt_reg == 4'h0) ? 4'h8 : out_cnt_reg) - {1'b0, dw_reg};
						if (out_cnt_reg == 4'h0) begin
							addr_reg <= addr_reg + 24'h000001;
						end
					end
					ST_WDATA: if (rise_e) begin
						sh_reg <= w_sh;
						cnt_reg <= cnt_w;
						if (cnt_w == 6'h08) begin
							cnt_reg <= 6'h00;
							prog_valid_reg <= 1'b1;
							prog_data_reg <= w_sh[7:0];
							prog_addr_reg <= addr_reg;
							addr_reg <= {addr_reg[23:`QSF_PAGE_LSB], addr_reg[7:0] + 8'h01};
						end
					end
					default: state_reg <= ST_DONE;
				endcase
			end
		end
	end

	task erase_kind_sel;
		input [1:0] k;
		begin
			case (k)
				`QSF_ER_SECT: erase_addr_reg <= {addr_reg[23:`QSF_SECT_LSB], 12'h000};
				`QSF_ER_B32: erase_addr_reg <= {addr_reg[23:`QSF_B32_LSB], 15'h0000};
				`QSF_ER_B64: erase_addr_reg <= {addr_reg[23:`QSF_B64_LSB], 16'h0000};
				default: erase_addr_reg <= 24'h000000;
			endcase
		end
	endtask

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	wire [3:0] oe_all = (drv_reg && state_reg == ST_RDATA && !cs_s && !hold_act) ?
		lane_mask(dw_reg) : 4'h0;
	assign io_lane_0_out = lane_o_reg[0];
	assign io_lane_1_out = lane_o_reg[1];
	assign io_lane_2_out = lane_o_reg[2];
	assign io_lane_3_out = lane_o_reg[3];
	assign io_lane_0_oe = oe_all[0];
	assign io_lane_1_oe = oe_all[1];
	assign io_lane_2_oe = oe_all[2];
	assign io_lane_3_oe = oe_all[3];
	assign four_lane_instruction_mode = qpi_reg;
	assign arr_rd_start = rd_start_reg;
	assign arr_rd_active = (state_reg == ST_DUMMY) || (state_reg == ST_RDATA);
	assign arr_rd_addr = addr_reg;
	assign prog_valid = prog_valid_reg;
	assign prog_addr = prog_addr_reg;
	assign prog_data = prog_data_reg;
	assign erase_valid = erase_valid_reg;
	assign erase_kind = ek_reg;
	assign erase_addr = erase_addr_reg;
	assign soft_reset = soft_rst_reg;
	assign cmd_reject = reject_reg;
	assign busy = (busy_cnt_reg != 16'h0000);
endmodule
`default_nettype wire

/* common/qsf_consts.vh */
// Constants for the quad serial flash interface
`ifndef QSF_CONSTS_VH
`define QSF_CONSTS_VH
// ------------------------------------------------------------
// Instruction codes
// ------------------------------------------------------------
`define QSF_CMD_QPI_ON 8'h38
`define QSF_CMD_QPI_OFF 8'hff
`define QSF_CMD_RST_EN 8'h66
`define QSF_CMD_RST 8'h99
`define QSF_CMD_READ 8'h03
`define QSF_CMD_FAST 8'h0b
`define QSF_CMD_DUAL_O 8'h3b
`define QSF_CMD_DUAL_IO 8'hbb
`define QSF_CMD_QUAD_O 8'h6b
`define QSF_CMD_QUAD_IO 8'heb
`define QSF_CMD_DTR_QIO 8'hed
`define QSF_CMD_PROG 8'h02
`define QSF_CMD_ER_4K 8'h20
`define QSF_CMD_ER_32K 8'h52
`define QSF_CMD_ER_64K 8'hd8
`define QSF_CMD_ER_CHIP 8'hc7
`define QSF_CMD_ER_CHIP2 8'h60
// ------------------------------------------------------------
// Dummy clocks per read instruction
// ------------------------------------------------------------
`define QSF_DUM_FAST 4'h8
`define QSF_DUM_DUAL_IO 4'h4
`define QSF_DUM_QUAD_IO 4'h6
`define QSF_DUM_DTR 4'h8
// ------------------------------------------------------------
// Array organisation
// ------------------------------------------------------------
`define QSF_ADDR_BITS 24
`define QSF_ADDR_LAST 6'h18
`define QSF_PAGE_LSB 8
`define QSF_SECT_LSB 12
`define QSF_B32_LSB 15
`define QSF_B64_LSB 16
`define QSF_ER_SECT 2'h0
`define QSF_ER_B32 2'h1
`define QSF_ER_B64 2'h2
`define QSF_ER_CHIP 2'h3
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define QSF_CLK_MHZ 25
`define QSF_SRST_NS 12000
`define QSF_SRST_CYC ((`QSF_SRST_NS * `QSF_CLK_MHZ + 999) / 1000)
`endif

/* logic/qsf_sync.v */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module qsf_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_reg;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* logic/qsf_buf2.v */
// Small FIFO buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module qsf_buf2 #(
	parameter WIDTH = 8,
	parameter DEPTH = 2,
	parameter AW = 1
) (
	input wire clk,
	input wire rst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam integer LAST_I = DEPTH - 1;
	localparam [AW:0] FULL = DEPTH[AW:0];
	localparam [AW-1:0] LAST = LAST_I[AW-1:0];
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wp_reg;
	reg [AW-1:0] rp_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;
	integer i;
	assign in_ready = (cnt_reg != FULL);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rp_reg];
	assign push = in_valid & in_ready & ~flush;
	assign pop = out_valid & out_ready & ~flush;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_reg[i] <= {WIDTH{1'b0}};
			end
		end else if (flush) begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_reg[wp_reg] <= in_data;
				wp_reg <= (wp_reg == LAST) ? {AW{1'b0}} : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == LAST) ? {AW{1'b0}} : rp_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/qsf_chk.sv */
// Assertion checker for the serial flash interface ports
`timescale 1ns/10ps
`default_nettype none
module qsf_chk (
	input wire ref_clk,
	input wire sys_rst,
	input wire spi_sck,
	input wire spi_cs_n,
	input wire quad_enable_bit,
	input wire io_lane_0_oe,
	input wire io_lane_1_oe,
	input wire io_lane_2_oe,
	input wire io_lane_3_oe,
	input wire io_lane_1_out,
	input wire four_lane_instruction_mode,
	input wire arr_rd_start,
	input wire arr_rd_active,
	input wire prog_valid,
	input wire [23:0] prog_addr,
	input wire erase_valid,
	input wire [1:0] erase_kind,
	input wire [23:0] erase_addr,
	input wire soft_reset,
	input wire busy
);
	reg [15:0] pg_reg;
	reg pg_ok_reg;
	reg [9:0] bcnt_reg;
	wire any_oe = io_lane_0_oe | io_lane_1_oe | io_lane_2_oe | io_lane_3_oe;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Page of the previous program byte and length of the busy period
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pg_reg <= 16'h0000;
			pg_ok_reg <= 1'b0;
			bcnt_reg <= 10'h000;
		end else begin
			bcnt_reg <= busy ? bcnt_reg + 10'h001 : 10'h000;
			pg_ok_reg <= spi_cs_n ? 1'b0 : (pg_ok_reg | prog_valid);
			if (prog_valid) pg_reg <= prog_addr[23:8];
		end
	end
	property p_desel_idle;
		spi_cs_n [*6] |-> !any_oe;
	endproperty
	a_desel_idle: assert property (p_desel_idle) else $error("lane driven while deselected");
	property p_qpi_qe;
		$rose(four_lane_instruction_mode) |-> quad_enable_bit;
	endproperty
	a_qpi_qe: assert property (p_qpi_qe) else $error("four-lane mode without quad enable");
	property p_quad_lanes;
		(io_lane_2_oe || io_lane_3_oe) |-> quad_enable_bit;
	endproperty
	a_quad_lanes: assert property (p_quad_lanes) else $error("upper lanes driven without quad enable");
	property p_rst_mode;
		soft_reset |-> ##[1:3] (busy && !four_lane_instruction_mode);
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("software reset did not return to single lane");
	property p_busy_len;
		$fell(busy) |-> (bcnt_reg >= 10'h12b && bcnt_reg <= 10'h12d);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy period length wrong");
	property p_prog_page;
		prog_valid && pg_ok_reg |-> prog_addr[23:8] == pg_reg;
	endproperty
	a_prog_page: assert property (p_prog_page) else $error("program left its page");
	property p_erase_align;
		erase_valid |-> (erase_kind == 2'h0 ? erase_addr[11:0] == 12'h000 :
			erase_kind == 2'h1 ? erase_addr[14:0] == 15'h0000 :
			erase_kind == 2'h2 ? erase_addr[15:0] == 16'h0000 : erase_addr == 24'h000000);
	endproperty
	a_erase_align: assert property (p_erase_align) else $error("erase base not aligned");
	property p_out_fall;
		$changed(io_lane_1_out) && io_lane_1_oe |-> !$past(spi_sck, 3) && $past(spi_sck, 4);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("read data moved after rising clock");
	property p_rd_start;
		arr_rd_start |-> ##[0:1] arr_rd_active;
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("read phase did not follow address");
endmodule
bind qsf_core qsf_chk chk_i (.*);
`default_nettype wire

/* tb/qsf_host.sv */
// Host controller model driving the flash link in clock mode 0 or 3
`timescale 1ns/10ps
`default_nettype none
module qsf_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic [3:0] h_oe,
	output logic [3:0] h_val,
	input wire logic [3:0] lane
);
	localparam int HALF = 160;
	logic m3;
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		h_oe = 4'h0;
		h_val = 4'h0;
		m3 = 1'b0;
	end
	// Clock idle level: low for mode 0, high for mode 3
	task mode(input m);
		begin
			m3 = m;
		end
	endtask
	task sel;
		begin
			#7 spi_sck = m3;
			#HALF spi_cs_n = 1'b0;
			#HALF spi_sck = 1'b0;
		end
	endtask
	task desel;
		begin
			#HALF spi_sck = m3;
			#HALF spi_cs_n = 1'b1;
			h_oe = 4'h0;
			#1000;
		end
	endtask
	task tick;
		begin
			#HALF spi_sck = 1'b1;
			#HALF spi_sck = 1'b0;
		end
	endtask
	task send(input [7:0] b, input integer w);
		integer i;
		begin
			for (i = 0; i < 8; i = i + w) begin
				h_oe = (w == 4) ? 4'hf : 4'h1;
				h_val = (w == 4) ? b[7-i -: 4] : {3'h0, b[7-i]};
				tick();
			end
		end
	endtask
	task recv(input integer w, output [7:0] b);
		integer i;
		begin
			b = 8'h00;
			h_oe = 4'h0;
			for (i = 0; i < 8; i = i + w) begin
				#HALF spi_sck = 1'b1;
				#(HALF - 10);
				b = (w == 4) ? {b[3:0], lane} : (w == 2) ? {b[5:0], lane[1:0]} : {b[6:0], lane[1]};
				#10 spi_sck = 1'b0;
			end
		end
	endtask
	task dummy(input integer n);
		begin
			h_oe = 4'h0;
			repeat (n) tick();
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench for the serial flash interface
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam [31:0] EC = 32'h2052d8c7;
	localparam [95:0] EA = {24'habc000, 24'hab8000, 24'hab0000, 24'h000000};
	localparam [31:0] RC = 32'h38eb6bed;
	reg ref_clk = 1'b0, sys_rst = 1'b1, quad_enable_bit = 1'b0, tgl = 1'b0, full_seen = 1'b0;
	reg [7:0] acnt = 8'h00, b;
	reg [23:0] st_addr = 24'h0, ea = 24'h0;
	reg [1:0] ek = 2'h0;
	reg [31:0] pq [$];
	integer ne = 0, nrj = 0, nsr = 0, cyc = 0, i, failures = 0, total_checks = 0;
	wire spi_sck, spi_cs_n, arr_rd_start, arr_rd_active, arr_rd_ready, prog_valid, erase_valid;
	wire soft_reset, cmd_reject, busy, four_lane_instruction_mode;
	wire [3:0] h_oe, h_val, l_oe, l_out, lane;
	wire [23:0] arr_rd_addr, prog_addr, erase_addr;
	wire [7:0] prog_data;
	wire [1:0] erase_kind;
	wire arr_rd_valid = arr_rd_active & ~arr_rd_start;
	wire [7:0] arr_rd_data = 8'ha0 + acnt;
	// Released lanes: upper pair pulled up, lower pair toggles
	assign lane = (l_oe & l_out) | (~l_oe & h_oe & h_val) | (~l_oe & ~h_oe & {2'b11, tgl, ~tgl});
	qsf_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .h_oe(h_oe), .h_val(h_val), .lane(lane));
	qsf_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.io_lane_0_in(lane[0]), .io_lane_0_out(l_out[0]), .io_lane_0_oe(l_oe[0]),
		.io_lane_1_in(lane[1]), .io_lane_1_out(l_out[1]), .io_lane_1_oe(l_oe[1]),
		.io_lane_2_in(lane[2]), .io_lane_2_out(l_out[2]), .io_lane_2_oe(l_oe[2]),
		.io_lane_3_in(lane[3]), .io_lane_3_out(l_out[3]), .io_lane_3_oe(l_oe[3]),
		.quad_enable_bit(quad_enable_bit), .four_lane_instruction_mode(four_lane_instruction_mode),
		.arr_rd_start(arr_rd_start), .arr_rd_active(arr_rd_active), .arr_rd_addr(arr_rd_addr),
		.arr_rd_data(arr_rd_data), .arr_rd_valid(arr_rd_valid), .arr_rd_ready(arr_rd_ready),
		.prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data),
		.erase_valid(erase_valid), .erase_kind(erase_kind), .erase_addr(erase_addr),
		.soft_reset(soft_reset), .cmd_reject(cmd_reject), .busy(busy));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// Array stream, captures of the block's outputs and the hang limit
	always @(posedge ref_clk) begin
		tgl <= ~tgl;
		cyc <= cyc + 1;
		acnt <= arr_rd_start ? 8'h00 : acnt + {7'h00, arr_rd_valid & arr_rd_ready};
		if (arr_rd_active & ~arr_rd_ready) full_seen <= 1'b1;
		if (arr_rd_start) st_addr <= arr_rd_addr;
		if (prog_valid) pq.push_back({prog_addr, prog_data});
		if (erase_valid) begin
			ne <= ne + 1;
			ek <= erase_kind;
			ea <= erase_addr;
		end
		if (soft_reset) nsr <= nsr + 1;
		if (cmd_reject) nrj <= nrj + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			print_verdict;
		end
	end
	task chk(input [31:0] g, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task addr(input [23:0] a, input integer w);
		begin
			host.send(a[23:16], w);
			host.send(a[15:8], w);
			host.send(a[7:0], w);
		end
	endtask
	task cmd(input [7:0] c, input integer w);
		begin
			host.sel();
			host.send(c, w);
			host.desel();
		end
	endtask
	task set_qe(input v);
		begin
			@(posedge ref_clk);
			#1 quad_enable_bit = v;
		end
	endtask
	task t_read;
		begin
			chk({busy, four_lane_instruction_mode, l_oe}, 32'h0);
			host.sel();
			host.send(8'h03, 1);
			addr(24'h123456, 1);
			host.recv(1, b);
			chk(st_addr, 32'h123456);
			chk(b, 32'ha0);
			host.recv(1, b);
			chk({l_oe, b}, {20'h0, 4'h2, 8'ha1});
			chk(full_seen, 32'h1);
			host.desel();
			chk(l_oe, 32'h0);
			$display("test read done");
		end
	endtask
	task t_prog;
		begin
			host.sel();
			host.send(8'h02, 1);
			addr(24'h0001fe, 1);
			host.send(8'h11, 1);
			host.send(8'h22, 1);
			host.send(8'h33, 1);
			host.desel();
			chk(pq.size(), 32'h3);
			chk(pq[0], 32'h0001fe11);
			chk(pq[2], 32'h00010033);
			$display("test program done");
		end
	endtask
	task t_erase;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				ne = 0;
				host.sel();
				host.send(EC[31-8*i -: 8], 1);
				if (i < 3) addr(24'habcdef, 1);
				host.desel();
				chk({ne[3:0], ek, ea}, {4'h1, i[1:0], EA[95-24*i -: 24]});
			end
			$display("test erase done");
		end
	endtask
	task t_reject;
		begin
			set_qe(1'b0);
			for (i = 0; i < 4; i = i + 1) begin
				host.sel();
				host.send(RC[31-8*i -: 8], 1);
				addr(24'h000100, 1);
				host.desel();
				chk(nrj, i + 1);
			end
			chk({st_addr, four_lane_instruction_mode}, {24'h123456, 1'b0});
			$display("test refusal done");
		end
	endtask
	task t_lanes;
		begin
			set_qe(1'b1);
			for (i = 0; i < 2; i = i + 1) begin
				host.sel();
				host.send(i ? 8'h6b : 8'h3b, 1);
				addr(24'h000040, 1);
				host.dummy(8);
				host.recv(i ? 4 : 2, b);
				chk({l_oe, b}, {20'h0, i ? 4'hf : 4'h3, 8'ha0});
				host.desel();
			end
			$display("test lanes done");
		end
	endtask
	task t_qpi;
		begin
			cmd(8'h38, 1);
			chk(four_lane_instruction_mode, 32'h1);
			cmd(8'h3b, 4);
			chk(nrj, 32'h5);
			cmd(8'h66, 4);
			cmd(8'h99, 4);
			chk({nsr[3:0], four_lane_instruction_mode}, {4'h1, 1'b0});
			cmd(8'h38, 1);
			chk(four_lane_instruction_mode, 32'h0);
			for (i = 0; i < 400 && busy !== 1'b0; i = i + 1) @(posedge ref_clk);
			chk(busy, 32'h0);
			cmd(8'h38, 1);
			cmd(8'hff, 4);
			chk(four_lane_instruction_mode, 32'h0);
			$display("test mode switch done");
		end
	endtask
	task t_mode3;
		begin
			host.mode(1'b1);
			host.sel();
			host.send(8'h03, 1);
			addr(24'h000777, 1);
			host.recv(1, b);
			host.desel();
			host.mode(1'b0);
			chk({st_addr, b}, {24'h000777, 8'ha0});
			$display("test clock mode 3 done");
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		repeat (8) @(posedge ref_clk);
		t_read;
		t_prog;
		t_erase;
		t_reject;
		t_lanes;
		t_qpi;
		t_mode3;
		print_verdict;
	end
endmodule
`default_nettype wire
